// >>> design/dadr_read_cmd.sv
// Purpose: task file, decode and completion of the DMA read commands
// Assumes: task file strobes and media stream are on clk_sys_i
// Notes: read data is registered, valid the cycle after the read strobe
`timescale 1ns/1ps
module dadr_read_cmd (
	input  wire logic                   clk_sys_i,
	input  wire logic                   rst_n_i,
	input  wire dadr_pkg::dadr_tf_req_t tf_i,
	output logic      [7:0]             tf_rdata_o,
	output logic                        tf_rdata_oe_o,
	output logic                        intrq_o,
	output logic                        dmarq_o,
	input  wire logic                   dmack_i,
	output logic      [15:0]            dma_data_o,
	output logic                        med_sec_req_o,
	output logic      [47:0]            med_lba_o,
	output logic                        med_lba_mode_o,
	input  wire dadr_pkg::dadr_med_in_t med_i,
	output logic                        med_ready_o
);
	typedef struct packed {
		dadr_pkg::dadr_state_t state;
		dadr_pkg::dadr_pair_t  feat;
		dadr_pkg::dadr_pair_t  cnt;
		dadr_pkg::dadr_pair_t  sect;
		dadr_pkg::dadr_pair_t  cyll;
		dadr_pkg::dadr_pair_t  cylh;
		logic [7:0]            devh;
		logic [7:0]            ctl;
		logic [7:0]            err;
		logic                  bsy;
		logic                  intrq;
		logic [7:0]            rdata;
		logic                  oe;
		logic [16:0]           remain;
		logic [47:0]           addr;
		logic                  ext;
		logic                  lba;
		logic                  sec_req;
	} dadr_core_t;

	dadr_core_t s_r;
	dadr_core_t s_nxt;

	logic [47:0] addr_next;
	logic        sec_done;
	logic        pacer_clear;
	logic [7:0]  status;
	logic        hob;
	logic        is_rd28;
	logic        is_rd48;
	logic        is_rdq;

	assign hob = s_r.ctl[dadr_pkg::CTL_HOB_BIT];
	// Low opcode bit is the retry request and is not decoded
	assign is_rd28 = (tf_i.wdata & dadr_pkg::OP_RD28_MASK) == dadr_pkg::OP_RD28;
	assign is_rd48 = tf_i.wdata == dadr_pkg::OP_RD48;
	assign is_rdq  = tf_i.wdata == dadr_pkg::OP_RDQ;
	assign pacer_clear = (s_r.state != dadr_pkg::ST_XFER);

	always_comb
	begin
		status = 8'h00;
		status[dadr_pkg::ST_BSY_BIT] = s_r.bsy;
		status[dadr_pkg::ST_RDY_BIT] = !s_r.bsy;
		status[dadr_pkg::ST_DSC_BIT] = !s_r.bsy;
		status[dadr_pkg::ST_ERR_BIT] = !s_r.bsy && (s_r.err != 8'h00);
	end

	dadr_addr_step u_step (
		.addr_i (s_r.addr),
		.lba_i  (s_r.lba),
		.next_o (addr_next)
	);

	dadr_word_pacer u_pacer (
		.clk_sys_i   (clk_sys_i),
		.rst_n_i     (rst_n_i),
		.clear_i     (pacer_clear),
		.med_i       (med_i),
		.med_ready_o (med_ready_o),
		.dmarq_o     (dmarq_o),
		.dmack_i     (dmack_i),
		.dma_data_o  (dma_data_o),
		.sec_done_o  (sec_done)
	);

	assign tf_rdata_o     = s_r.rdata;
	assign tf_rdata_oe_o  = s_r.oe;
	assign intrq_o        = s_r.intrq;
	assign med_sec_req_o  = s_r.sec_req;
	assign med_lba_o      = s_r.addr;
	assign med_lba_mode_o = s_r.lba;

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.sec_req = 1'b0;
		s_nxt.oe = tf_i.rd;

		// Register reads, high-order bytes when selected
		if (tf_i.rd)
		begin
			if (tf_i.ctl)
				s_nxt.rdata = status;
			else
			begin
				case (tf_i.addr)
					dadr_pkg::TF_FEAT: s_nxt.rdata = s_r.err;
					dadr_pkg::TF_CNT:  s_nxt.rdata = hob ? s_r.cnt.prev : s_r.cnt.cur;
					dadr_pkg::TF_SECT: s_nxt.rdata = hob ? s_r.sect.prev : s_r.sect.cur;
					dadr_pkg::TF_CYLL: s_nxt.rdata = hob ? s_r.cyll.prev : s_r.cyll.cur;
					dadr_pkg::TF_CYLH: s_nxt.rdata = hob ? s_r.cylh.prev : s_r.cylh.cur;
					dadr_pkg::TF_DEVH: s_nxt.rdata = s_r.devh;
					dadr_pkg::TF_CMD:  s_nxt.rdata = status;
					default:           s_nxt.rdata = 8'h00;
				endcase
				// Status read acknowledges the interrupt
				if (tf_i.addr == dadr_pkg::TF_CMD)
					s_nxt.intrq = 1'b0;
			end
		end

		if (tf_i.wr && tf_i.ctl && tf_i.addr == dadr_pkg::TF_CTL)
			s_nxt.ctl = tf_i.wdata;

		// Command block writes are ignored while busy
		if (tf_i.wr && !tf_i.ctl && !s_r.bsy)
		begin
			case (tf_i.addr)
				dadr_pkg::TF_FEAT: s_nxt.feat = '{cur: tf_i.wdata, prev: s_r.feat.cur};
				dadr_pkg::TF_CNT:  s_nxt.cnt  = '{cur: tf_i.wdata, prev: s_r.cnt.cur};
				dadr_pkg::TF_SECT: s_nxt.sect = '{cur: tf_i.wdata, prev: s_r.sect.cur};
				dadr_pkg::TF_CYLL: s_nxt.cyll = '{cur: tf_i.wdata, prev: s_r.cyll.cur};
				dadr_pkg::TF_CYLH: s_nxt.cylh = '{cur: tf_i.wdata, prev: s_r.cylh.cur};
				dadr_pkg::TF_DEVH: s_nxt.devh = tf_i.wdata;
				dadr_pkg::TF_CMD:
				begin
					// Host channel is expected armed before this write
					s_nxt.intrq = 1'b0;
					s_nxt.err = 8'h00;
					s_nxt.bsy = 1'b1;
					s_nxt.ctl[dadr_pkg::CTL_HOB_BIT] = 1'b0;
					s_nxt.ext = !is_rd28;
					s_nxt.lba = is_rd28 ? s_r.devh[dadr_pkg::DH_LBA_BIT] : 1'b1;
					s_nxt.addr = {s_r.cylh.prev, s_r.cyll.prev, s_r.sect.prev,
						s_r.cylh.cur, s_r.cyll.cur, s_r.sect.cur};
					if (is_rd28)
					begin
						// Head number or LBA 24-27 share the low nibble
						s_nxt.addr[47:24] = {20'h00000, s_r.devh[3:0]};
						s_nxt.remain = (s_r.cnt.cur == 8'h00) ? dadr_pkg::CNT28_ZERO
							: {9'h000, s_r.cnt.cur};
					end
					else if (is_rd48)
						s_nxt.remain = ({s_r.cnt.prev, s_r.cnt.cur} == 16'h0000) ? dadr_pkg::CNT48_ZERO
							: {1'b0, s_r.cnt.prev, s_r.cnt.cur};
					else
						s_nxt.remain = ({s_r.feat.prev, s_r.feat.cur} == 16'h0000) ? dadr_pkg::CNT48_ZERO
							: {1'b0, s_r.feat.prev, s_r.feat.cur};
					if (is_rd28 || is_rd48 || is_rdq)
						s_nxt.state = dadr_pkg::ST_ISSUE;
					else
					begin
						s_nxt.err[dadr_pkg::ER_ABT_BIT] = 1'b1;
						s_nxt.state = dadr_pkg::ST_DONE;
					end
				end
				default: s_nxt.state = s_r.state;
			endcase
		end

		case (s_r.state)
			dadr_pkg::ST_IDLE: s_nxt.bsy = s_nxt.bsy;
			dadr_pkg::ST_ISSUE:
			begin
				s_nxt.sec_req = 1'b1;
				s_nxt.state = dadr_pkg::ST_XFER;
			end
			dadr_pkg::ST_XFER:
			begin
				if (med_i.valid && med_i.err)
				begin
					// Failing sector ends the read; no later sector is asked for
					s_nxt.err[dadr_pkg::ER_UNC_BIT] = 1'b1;
					s_nxt.state = dadr_pkg::ST_DONE;
				end
				else if (sec_done)
				begin
					s_nxt.remain = s_r.remain - 17'h00001;
					if (s_r.remain == 17'h00001)
						s_nxt.state = dadr_pkg::ST_DONE;
					else
					begin
						s_nxt.addr = addr_next;
						s_nxt.state = dadr_pkg::ST_ISSUE;
					end
				end
			end
			dadr_pkg::ST_DONE:
			begin
				// Address stays on the last or failing sector
				s_nxt.cnt = '{cur: s_r.remain[7:0], prev: s_r.remain[15:8]};
				s_nxt.sect = '{cur: s_r.addr[7:0], prev: s_r.addr[31:24]};
				s_nxt.cyll = '{cur: s_r.addr[15:8], prev: s_r.addr[39:32]};
				s_nxt.cylh = '{cur: s_r.addr[23:16], prev: s_r.addr[47:40]};
				if (!s_r.ext)
					s_nxt.devh[3:0] = s_r.addr[27:24];
				s_nxt.bsy = 1'b0;
				// Set after any clear above, so the event wins
				s_nxt.intrq = 1'b1;
				s_nxt.state = dadr_pkg::ST_IDLE;
			end
			default: s_nxt.state = dadr_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			s_r <= '0;
			s_r.state <= dadr_pkg::ST_IDLE;
			s_r.devh <= dadr_pkg::DEVH_RESET;
		end
		else
			s_r <= s_nxt;
	end
endmodule

// >>> design/dadr_pkg.sv
// Purpose: constants and types for the DMA read command block
// Assumes: task file is driven by logic on clk_sys_i
// Notes: opcodes and bit positions for dadr_read_cmd, types and sizes shared by all design files
// Operation
// - Retry bit of the 28-bit DMA read opcode is ignored.
// - 28-bit LBA mode: device/head low nibble is LBA bits 24-27, else head.
// - 28-bit completion: sector count returns sectors not transferred.
// - 28-bit completion: sector number holds last sector, or LBA 0-7.
// - 28-bit completion: cylinder registers hold last cylinder, or LBA 8-23.
// - 28-bit completion: device/head low nibble holds head, or LBA 24-27.
// - Opcode 25h is the 48-bit DMA read.
// - Sector data goes to the host as 16-bit words.
// - Each word is paced by DMA request and moved by the host channel.
// - Exactly one interrupt per DMA read command.
// - Uncorrectable error stops the read at the failing sector.
// - 48-bit count: current byte bits 7:0, previous byte bits 15:8.
// - 48-bit count of zero means 65,536 sectors.
// - 48-bit LBA built from current and previous address bytes.
// - 48-bit error: failing LBA readable, high-order select picks upper bytes.
// - Opcode 60h is the queued read, ending at a failing sector.
// - 28-bit mode bit 1 selects LBA, 0 selects cylinder/head/sector.
// - 28-bit count of zero means 256 sectors.
// - Queued read count comes from the feature register pair.
package dadr_pkg;
	localparam logic [7:0] OP_RD28       = 8'hC8;
	localparam logic [7:0] OP_RD28_MASK  = 8'hFE;
	localparam logic [7:0] OP_RD48       = 8'h25;
	localparam logic [7:0] OP_RDQ        = 8'h60;
	localparam logic [2:0] TF_DATA       = 3'h0;
	localparam logic [2:0] TF_FEAT       = 3'h1;
	localparam logic [2:0] TF_CNT        = 3'h2;
	localparam logic [2:0] TF_SECT       = 3'h3;
	localparam logic [2:0] TF_CYLL       = 3'h4;
	localparam logic [2:0] TF_CYLH       = 3'h5;
	localparam logic [2:0] TF_DEVH       = 3'h6;
	localparam logic [2:0] TF_CMD        = 3'h7;
	localparam logic [2:0] TF_CTL        = 3'h6;
	localparam int         DH_LBA_BIT    = 6;
	localparam int         CTL_HOB_BIT   = 7;
	localparam int         ER_UNC_BIT    = 6;
	localparam int         ER_ABT_BIT    = 2;
	localparam int         ST_BSY_BIT    = 7;
	localparam int         ST_RDY_BIT    = 6;
	localparam int         ST_DSC_BIT    = 4;
	localparam int         ST_ERR_BIT    = 0;
	localparam logic [16:0] CNT28_ZERO   = 17'h00100;
	localparam logic [16:0] CNT48_ZERO   = 17'h10000;
	localparam logic [8:0] WORDS_PER_SEC = 9'h100;
	localparam logic [7:0] CHS_SPT       = 8'h3F;
	localparam logic [3:0] CHS_HEADS     = 4'hF;
	localparam logic [7:0] DEVH_RESET    = 8'hA0;

	typedef struct packed {
		logic [7:0] cur;
		logic [7:0] prev;
	} dadr_pair_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic       ctl;
		logic [2:0] addr;
		logic [7:0] wdata;
	} dadr_tf_req_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] word;
		logic        err;
	} dadr_med_in_t;

	typedef enum {ST_IDLE, ST_ISSUE, ST_XFER, ST_DONE} dadr_state_t;
endpackage

// >>> design/dadr_addr_step.sv
// Purpose: next sector address in LBA or cylinder/head/sector form
// Assumes: CHS kept as sector [7:0], cylinder [23:8], head [27:24]
// Notes: pure combinational, no state
`timescale 1ns/1ps
module dadr_addr_step (
	input  wire logic [47:0] addr_i,
	input  wire logic        lba_i,
	output logic      [47:0] next_o
);
	always_comb
	begin
		next_o = addr_i;
		if (lba_i)
			next_o = addr_i + 48'h1;
		else if (addr_i[7:0] < dadr_pkg::CHS_SPT)
			next_o[7:0] = addr_i[7:0] + 8'h01;
		else
		begin
			next_o[7:0] = 8'h01;
			// Head wraps into the next cylinder
			if (addr_i[27:24] < dadr_pkg::CHS_HEADS)
				next_o[27:24] = addr_i[27:24] + 4'h1;
			else
			begin
				next_o[27:24] = 4'h0;
				next_o[23:8] = addr_i[23:8] + 16'h0001;
			end
		end
	end
endmodule

// >>> design/dadr_word_pacer.sv
// Purpose: holds one media word and paces it to the host DMA channel
// Assumes: host acks one word per cycle at most
// Notes: media stalls whenever the word is not yet taken
`timescale 1ns/1ps
module dadr_word_pacer (
	input  wire logic                   clk_sys_i,
	input  wire logic                   rst_n_i,
	input  wire logic                   clear_i,
	input  wire dadr_pkg::dadr_med_in_t med_i,
	output logic                        med_ready_o,
	output logic                        dmarq_o,
	input  wire logic                   dmack_i,
	output logic      [15:0]            dma_data_o,
	output logic                        sec_done_o
);
	typedef struct packed {
		logic        full;
		logic [15:0] data;
		logic [8:0]  words;
	} dadr_pacer_t;

	dadr_pacer_t s_r;
	dadr_pacer_t s_nxt;

	assign med_ready_o = !s_r.full && !clear_i;
	assign dmarq_o     = s_r.full;
	assign dma_data_o  = s_r.data;
	assign sec_done_o  = s_r.full && dmack_i && (s_r.words == dadr_pkg::WORDS_PER_SEC - 9'h001);

	always_comb
	begin
		s_nxt = s_r;
		if (s_r.full && dmack_i)
		begin
			s_nxt.full = 1'b0;
			s_nxt.words = sec_done_o ? 9'h000 : s_r.words + 9'h001;
		end
		if (med_ready_o && med_i.valid && !med_i.err)
		begin
			s_nxt.full = 1'b1;
			s_nxt.data = med_i.word;
		end
		if (clear_i)
		begin
			s_nxt.full = 1'b0;
			s_nxt.words = 9'h000;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end
endmodule

// >>> sim/dadr_assertions.sv
// Purpose: port checks for the DMA read block
// Assumes: one clock, async active-low reset
// Notes: busy is inferred from command writes and interrupts
`timescale 1ns/1ps
module dadr_checker (
	input wire logic                   clk_sys_i,
	input wire logic                   rst_n_i,
	input wire dadr_pkg::dadr_tf_req_t tf_i,
	input wire logic                   intrq_o,
	input wire logic                   dmarq_o,
	input wire logic                   dmack_i,
	input wire logic [15:0]            dma_data_o,
	input wire logic                   med_sec_req_o
);
	logic       busy_r;
	logic [1:0] irqs_r;
	logic       irq_d;
	logic       cmd_w;
	logic       rd_op;
	logic       st_rd;
	assign cmd_w = tf_i.wr && !tf_i.ctl && tf_i.addr == 3'h7;
	assign rd_op = cmd_w && tf_i.wdata inside {8'hC8, 8'hC9, 8'h25, 8'h60};
	assign st_rd = tf_i.rd && !tf_i.ctl && tf_i.addr == 3'h7;
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			busy_r <= 1'b0;
			irqs_r <= 2'h0;
			irq_d  <= 1'b0;
		end
		else
		begin
			busy_r <= cmd_w || (busy_r && !intrq_o);
			irq_d  <= intrq_o;
			// Rising edges counted by hand, no sampled-value call outside properties
			irqs_r <= cmd_w ? 2'h0 : irqs_r + {1'b0, intrq_o && !irq_d};
		end
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_issue;
		##[1:3] med_sec_req_o;
	endsequence
	sequence s_abort;
		!med_sec_req_o[*3] ##[0:2] intrq_o;
	endsequence
	a_cmd_issue: assert property (rd_op && !busy_r |-> s_issue)
		else $error("read command not issued");
	a_bad_abort: assert property (cmd_w && !rd_op && !busy_r |-> s_abort)
		else $error("bad opcode not aborted");
	a_word_held: assert property (dmarq_o && !dmack_i |=> dmarq_o && $stable(dma_data_o))
		else $error("word dropped before ack");
	a_irq_stands: assert property (intrq_o && !st_rd && !cmd_w |=> intrq_o)
		else $error("interrupt lost");
	a_irq_clear: assert property (intrq_o && st_rd |=> !intrq_o)
		else $error("status read kept interrupt");
	a_one_irq: assert property (irqs_r <= 2'h1)
		else $error("second interrupt");
	a_done_quiet: assert property (intrq_o |-> !med_sec_req_o && !dmarq_o)
		else $error("traffic after end");
	a_idle_quiet: assert property (!busy_r && !cmd_w |-> !dmarq_o && !med_sec_req_o)
		else $error("traffic while idle");
endmodule

// >>> sim/dadr_host_dma.sv
// Purpose: host slave DMA channel model
// Assumes: one ack a cycle, or every other cycle when slow
// Notes: keeps a count and the last word taken
`timescale 1ns/1ps
module dadr_host_dma (
	input  wire logic        clk_sys_i,
	input  wire logic        dmarq_i,
	input  wire logic [15:0] data_i,
	input  wire logic        slow_i,
	output logic             dmack_o,
	output int               n_words_o,
	output logic      [15:0] last_o
);
	logic ph;
	// Channel armed from time zero, ahead of any command
	initial
	begin
		dmack_o = 1'b0;
		n_words_o = 0;
		last_o = 16'h0000;
		ph = 1'b0;
	end
	always @(posedge clk_sys_i)
	begin
		if (dmack_o && dmarq_i)
		begin
			n_words_o <= n_words_o + 1;
			last_o <= data_i;
		end
		#1;
		ph = !ph;
		// Only moves a word the device asks for
		dmack_o = dmarq_i && (!slow_i || ph);
	end
endmodule

// >>> sim/dadr_read_cmd_test.sv
// Purpose: self-checking bench for the DMA read block
// Assumes: host model on the far side, bench feeds the media side
// Notes: zero counts run three sectors, then a mid-run reset cuts them short
`timescale 1ns/1ps
module dadr_read_cmd_test;
	logic                   clk_sys_i;
	logic                   rst_n_i;
	dadr_pkg::dadr_tf_req_t tf_i;
	logic [7:0]             tf_rdata_o;
	logic                   tf_rdata_oe_o;
	logic                   intrq_o;
	logic                   dmarq_o;
	logic                   dmack_i;
	logic [15:0]            dma_data_o;
	logic                   med_sec_req_o;
	logic [47:0]            med_lba_o;
	logic                   med_lba_mode_o;
	dadr_pkg::dadr_med_in_t med_i;
	logic                   med_ready_o;
	logic                   slow;
	int                     n_words;
	logic [15:0]            last_w;
	int                     n0;
	int                     bad_count;
	int                     n_tests;
	dadr_read_cmd dadr_read_cmd_i (.clk_sys_i, .rst_n_i, .tf_i, .tf_rdata_o, .tf_rdata_oe_o, .intrq_o,
		.dmarq_o, .dmack_i, .dma_data_o, .med_sec_req_o, .med_lba_o, .med_lba_mode_o, .med_i, .med_ready_o);
	dadr_host_dma dadr_host_dma_i (.clk_sys_i, .dmarq_i(dmarq_o), .data_i(dma_data_o), .slow_i(slow),
		.dmack_o(dmack_i), .n_words_o(n_words), .last_o(last_w));
	always #4 clk_sys_i = !clk_sys_i;
	task automatic report_and_stop;
		if (bad_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tmo(input int k, input int lim);
		if (k >= lim)
		begin
			bad_count++;
			report_and_stop();
		end
	endtask
	task automatic tick;
		@(posedge clk_sys_i);
		#1;
	endtask
	task automatic wr(input logic c, input logic [2:0] a, input logic [7:0] d);
		tf_i = '{1'b1, 1'b0, c, a, d};
		tick();
		tf_i = '0;
		// Idle cycle keeps back-to-back strobes apart
		tick();
	endtask
	task automatic rdc(input logic c, input logic [2:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
		tf_i = '{1'b0, 1'b1, c, a, 8'h00};
		tick();
		tf_i = '0;
		chk(tf_rdata_oe_o, 1'b1);
		chk(tf_rdata_o & m, e);
		tick();
	endtask
	// Count, sector, cylinder low/high, device/head in one go
	task automatic ld(input logic [7:0] v [5]);
		for (int i = 0; i < 5; i++)
			wr(1'b0, 3'(i + 2), v[i]);
	endtask
	task automatic rd3(input logic [7:0] v [3]);
		for (int i = 0; i < 3; i++)
			rdc(1'b0, 3'(i + 3), v[i]);
	endtask
	task automatic sec(input logic [47:0] lba, input logic [15:0] b, input logic e);
		int k;
		// Request pulse is looked at after the edge, while it stands
		for (k = 0; k < 60 && med_sec_req_o !== 1'b1; k++)
			tick();
		tmo(k, 60);
		chk(med_lba_o, lba);
		for (int i = 0; i < (e ? 1 : 256); i++)
		begin
			med_i = '{1'b1, b + i[15:0], e};
			for (k = 0; k < 40; k++)
			begin
				@(posedge clk_sys_i);
				if (med_ready_o === 1'b1 || e)
					break;
			end
			tmo(k, 40);
			#1;
		end
		// Released bus shows garbage, not the last word
		med_i = '{1'b0, ~b, 1'b0};
	endtask
	task automatic wait_irq;
		int k;
		for (k = 0; k < 3000 && intrq_o !== 1'b1; k++)
			tick();
		tmo(k, 3000);
	endtask
	initial
	begin
		clk_sys_i = 1'b0;
		rst_n_i = 1'b0;
		tf_i = '0;
		med_i = '0;
		slow = 1'b0;
		bad_count = 0;
		n_tests = 0;
		repeat (12) @(posedge clk_sys_i);
		#1;
		rst_n_i = 1'b1;
		rdc(1'b0, 3'h7, 8'h50);
		rdc(1'b0, 3'h6, 8'hA0);
		ld('{8'h01, 8'h56, 8'h34, 8'h12, 8'hE3});
		n0 = n_words;
		wr(1'b0, 3'h7, 8'hC9);
		sec(48'h3123456, 16'h1000, 1'b0);
		chk(med_lba_mode_o, 1'b1);
		wait_irq();
		chk(n_words - n0, 256);
		chk(last_w, 16'h10FF);
		rdc(1'b0, 3'h2, 8'h00);
		rd3('{8'h56, 8'h34, 8'h12});
		rdc(1'b0, 3'h6, 8'h03, 8'h0F);
		rdc(1'b1, 3'h7, 8'h50);
		chk(intrq_o, 1'b1);
		rdc(1'b0, 3'h7, 8'h50);
		chk(intrq_o, 1'b0);
		slow = 1'b1;
		ld('{8'h02, 8'h3F, 8'h05, 8'h00, 8'hA2});
		wr(1'b0, 3'h7, 8'hC8);
		sec(48'h200053F, 16'h2000, 1'b0);
		chk(med_lba_mode_o, 1'b0);
		sec(48'h3000501, 16'h2100, 1'b0);
		wait_irq();
		rd3('{8'h01, 8'h05, 8'h00});
		rdc(1'b0, 3'h6, 8'h03, 8'h0F);
		rdc(1'b0, 3'h7, 8'h50);
		slow = 1'b0;
		ld('{8'h00, 8'hAB, 8'hCD, 8'hEF, 8'h40});
		ld('{8'h02, 8'h10, 8'h20, 8'h30, 8'h40});
		n0 = n_words;
		wr(1'b0, 3'h7, 8'h25);
		sec(48'hEFCDAB302010, 16'h3000, 1'b0);
		sec(48'hEFCDAB302011, 16'h0000, 1'b1);
		wait_irq();
		chk(n_words - n0, 256);
		rdc(1'b0, 3'h1, 8'h40);
		rdc(1'b0, 3'h2, 8'h01);
		rd3('{8'h11, 8'h20, 8'h30});
		wr(1'b1, 3'h6, 8'h80);
		rd3('{8'hAB, 8'hCD, 8'hEF});
		rdc(1'b0, 3'h7, 8'h51);
		wr(1'b0, 3'h1, 8'h00);
		wr(1'b0, 3'h1, 8'h01);
		ld('{8'h00, 8'h00, 8'h00, 8'h00, 8'h40});
		ld('{8'h08, 8'h05, 8'h00, 8'h00, 8'h40});
		wr(1'b0, 3'h7, 8'h60);
		sec(48'h5, 16'h4000, 1'b0);
		wait_irq();
		rdc(1'b0, 3'h7, 8'h50);
		wr(1'b0, 3'h7, 8'hA5);
		wait_irq();
		rdc(1'b0, 3'h1, 8'h04);
		rdc(1'b0, 3'h7, 8'h51);
		// Zero count: a third sector request proves it is not taken as 1 or 2
		ld('{8'h00, 8'h00, 8'h00, 8'h00, 8'h40});
		wr(1'b0, 3'h7, 8'hC8);
		sec(48'h0, 16'h5000, 1'b0);
		sec(48'h1, 16'h5100, 1'b0);
		sec(48'h2, 16'h5200, 1'b0);
		chk(intrq_o, 1'b0);
		// Full run would take too long, so reset in mid-command
		rst_n_i = 1'b0;
		tick();
		rst_n_i = 1'b1;
		rdc(1'b0, 3'h7, 8'h50);
		rdc(1'b0, 3'h6, 8'hA0);
		ld('{8'h00, 8'h00, 8'h00, 8'h00, 8'h40});
		wr(1'b0, 3'h7, 8'h25);
		sec(48'h0, 16'h6000, 1'b0);
		sec(48'h1, 16'h6100, 1'b0);
		sec(48'h2, 16'h6200, 1'b0);
		chk(intrq_o, 1'b0);
		rst_n_i = 1'b0;
		tick();
		rst_n_i = 1'b1;
		rdc(1'b0, 3'h7, 8'h50);
		report_and_stop();
	end
endmodule
bind dadr_read_cmd dadr_checker dadr_checker_i (.clk_sys_i, .rst_n_i, .tf_i, .intrq_o, .dmarq_o, .dmack_i,
	.dma_data_o, .med_sec_req_o);
